// *** hw/scp_pkg.sv ***
package scp_pkg;

	// data path width shared by every unit
	localparam int XLEN = 32;
	localparam int NREG = 16;
	localparam int RIDX_W = 4;

	// processor cycle built from two clock phases
	localparam int CYCLE_NS = 200;
	localparam int CLK_MHZ = 10;
	localparam int PH_PER_CYC = (CYCLE_NS * CLK_MHZ) / 1000;

	// instruction word layout
	localparam int OP_HI = 31;
	localparam int OP_LO = 28;
	localparam int AM_HI = 27;
	localparam int AM_LO = 26;
	localparam int RD_HI = 25;
	localparam int RD_LO = 22;
	localparam int RS_HI = 21;
	localparam int RS_LO = 18;
	localparam int RX_HI = 17;
	localparam int RX_LO = 14;
	localparam int DISP_HI = 13;
	localparam int DISP_LO = 0;
	localparam int DISP_W = DISP_HI - DISP_LO + 1;
	localparam int BCNT_HI = 3;
	localparam int BCNT_LO = 0;

	// multi-cycle stage occupancy, in processor cycles
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] AC_LAST = 4'h1;
	localparam logic [CNT_W-1:0] MUL_LAST = 4'h3;

	// control settings prepared by decode
	localparam int CTL_MRD = 0;
	localparam int CTL_MWR = 1;
	localparam int CTL_RWR = 2;
	localparam int CTL_AMM = 3;
	localparam int CTL_FLG = 4;
	localparam int CTL_W = 5;

	// condition flags
	localparam int FL_C = 0;
	localparam int FL_N = 1;
	localparam int FL_Z = 2;
	localparam int FL_W = 3;

	localparam logic [XLEN-1:0] PC_RST = 32'h0000_0000;
	localparam logic [XLEN-1:0] PC_STEP = 32'h0000_0004;

	typedef enum logic [3:0] {
		OP_NOP    = 4'h0,
		OP_ADD_RR = 4'h1,
		OP_LD_RR  = 4'h2,
		OP_ADD_MR = 4'h3,
		OP_LD_M   = 4'h4,
		OP_ST_M   = 4'h5,
		OP_MUL    = 4'h6,
		OP_BMOV   = 4'h7
	} scp_op_t;

	typedef enum logic [1:0] {
		AM_DIRECT   = 2'h0,
		AM_BASE_IDX = 2'h1,
		AM_REL      = 2'h2,
		AM_REL_IDX  = 2'h3
	} scp_am_t;

	typedef enum logic {
		PH1 = 1'h0,
		PH2 = 1'h1
	} scp_phase_t;

	// one pipeline slot as it moves from stage to stage
	typedef struct packed {
		logic             valid;
		logic [XLEN-1:0]  ir;
		logic [XLEN-1:0]  pc;
		logic [XLEN-1:0]  ea;
		logic [XLEN-1:0]  opnd;
		logic [XLEN-1:0]  res;
		logic [CTL_W-1:0] ctl;
		logic [FL_W-1:0]  fl;
	} scp_slot_t;

endpackage

// *** hw/scp_stage_if.sv ***
`timescale 1ns/1ps
interface scp_stage_if;
	scp_pkg::scp_slot_t slot;

	modport src (output slot);
	modport snk (input slot);
endinterface

// *** hw/scp_stage.sv ***
`timescale 1ns/1ps
module scp_stage (
	input  wire logic   clk_sys,
	input  wire logic   rst_n,
	input  wire logic   adv,
	scp_stage_if.snk    nx,
	scp_stage_if.src    st
);
	scp_pkg::scp_slot_t slot_d;
	scp_pkg::scp_slot_t slot_q;

	// a stage only takes new work on a processor-cycle boundary
	always_comb begin
		slot_d = adv ? nx.slot : slot_q;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slot_q <= '0;
		end else begin
			slot_q <= slot_d;
		end
	end

	assign st.slot = slot_q;
endmodule

// *** hw/scp_pipe.sv ***
`timescale 1ns/1ps
// Operation
// - six stages in order; all stages work on different instructions at once
// - each stage takes one processor cycle of two clock phases, 200 ns
// - fetch advances the program counter and starts cache instruction reads
// - decode takes fetched words and prepares address stage control
// - address calc is one cycle, two for indexed and relative modes
// - translation buffer supplies the physical address after address calc
// - operand fetch reads cache data into a holding register
// - execute is one cycle; multiply and block move take several
// - register results are written to the register file in execute
// - memory results go to cache and external memory in operand store
// - condition flags are updated in operand store, not execute
// - cache serves one instruction and one operand reference per cycle
// - instruction fetch compares tags in phase two, accesses data in one
// - operand access compares tags in phase one, accesses data in two
// - simple instructions retire one per processor cycle without stalls
// - all units and data paths are 32 bits wide
// - translation buffer maps address-unit logical addresses to physical
module scp_pipe (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic [scp_pkg::XLEN-1:0]  ic_rdata,
	input  wire logic                      ic_hit,
	input  wire logic [scp_pkg::XLEN-1:0]  tlb_paddr,
	input  wire logic [scp_pkg::XLEN-1:0]  dc_rdata,
	input  wire logic                      dc_ready,
	output logic                           phase_q,
	output logic [scp_pkg::XLEN-1:0]       ic_addr_q,
	output logic                           ic_tag_q,
	output logic                           ic_rd_q,
	output logic [scp_pkg::XLEN-1:0]       tlb_laddr_q,
	output logic                           tlb_req_q,
	output logic [scp_pkg::XLEN-1:0]       dc_addr_q,
	output logic                           dc_tag_q,
	output logic                           dc_rd_q,
	output logic                           dc_wr_q,
	output logic [scp_pkg::XLEN-1:0]       dc_wdata_q,
	output logic                           ext_wr_q,
	output logic                           rf_we_q,
	output logic [scp_pkg::RIDX_W-1:0]     rf_waddr_q,
	output logic [scp_pkg::XLEN-1:0]       rf_wdata_q,
	output logic [scp_pkg::FL_W-1:0]       flags_q,
	output logic                           retire_q
);
	localparam int XL = scp_pkg::XLEN;

	logic                      rst_meta_q;
	logic                      rst_q_n;
	scp_pkg::scp_phase_t       ph_q;
	scp_pkg::scp_phase_t       ph_d;
	logic                      tick;
	logic [5:1]                busy;
	logic [5:1]                hold;
	logic [5:1]                adv;
	scp_pkg::scp_slot_t        nxs [1:5];
	scp_pkg::scp_slot_t        sts [1:5];
	scp_pkg::scp_slot_t        of_next;
	logic [XL-1:0]             rf_q [scp_pkg::NREG];
	logic [XL-1:0]             pc_q, pc_d, fa_q, fa_d, fbuf_q, fbuf_d;
	logic                      fa_ok_q, fa_ok_d, fbuf_v_q, fbuf_v_d;
	logic [scp_pkg::CNT_W-1:0] ac_cnt_q, ac_cnt_d, ex_cnt_q, ex_cnt_d;
	logic [scp_pkg::CNT_W-1:0] ex_last;
	logic                      ac_mc, raw, of_rd, os_st;
	logic [XL-1:0]             ea_calc, ex_a, ex_b, add_b, ex_res;
	logic [XL:0]               sum33;
	logic [scp_pkg::FL_W-1:0]  ex_fl;
	logic                      rf_we_d;
	logic [scp_pkg::RIDX_W-1:0] rf_waddr_d;
	logic [XL-1:0]             rf_wdata_d;
	logic [XL-1:0]             ic_addr_d, dc_addr_d, tlb_laddr_d, dc_wdata_d;
	logic                      ic_tag_d, ic_rd_d, tlb_req_d;
	logic                      dc_tag_d, dc_rd_d, dc_wr_d, retire_d;
	logic [scp_pkg::FL_W-1:0]  flags_d;

	// field helpers
	function automatic scp_pkg::scp_op_t op_of(input logic [XL-1:0] ir);
		op_of = scp_pkg::scp_op_t'(ir[scp_pkg::OP_HI:scp_pkg::OP_LO]);
	endfunction

	function automatic logic [scp_pkg::RIDX_W-1:0] rd_of(
		input logic [XL-1:0] ir);
		rd_of = ir[scp_pkg::RD_HI:scp_pkg::RD_LO];
	endfunction

	function automatic logic [scp_pkg::RIDX_W-1:0] rs_of(
		input logic [XL-1:0] ir);
		rs_of = ir[scp_pkg::RS_HI:scp_pkg::RS_LO];
	endfunction

	function automatic logic [scp_pkg::RIDX_W-1:0] rx_of(
		input logic [XL-1:0] ir);
		rx_of = ir[scp_pkg::RX_HI:scp_pkg::RX_LO];
	endfunction

	// decode into the control settings the later stages act on
	function automatic logic [scp_pkg::CTL_W-1:0] decode(
		input logic [XL-1:0] ir);
		scp_pkg::scp_op_t          op;
		scp_pkg::scp_am_t          am;
		logic [scp_pkg::CTL_W-1:0] c;
		op = op_of(ir);
		am = scp_pkg::scp_am_t'(ir[scp_pkg::AM_HI:scp_pkg::AM_LO]);
		c = '0;
		c[scp_pkg::CTL_MRD] = (op == scp_pkg::OP_ADD_MR) ||
			(op == scp_pkg::OP_LD_M) || (op == scp_pkg::OP_BMOV);
		c[scp_pkg::CTL_MWR] = (op == scp_pkg::OP_ST_M) ||
			(op == scp_pkg::OP_BMOV);
		c[scp_pkg::CTL_RWR] = (op == scp_pkg::OP_ADD_RR) ||
			(op == scp_pkg::OP_LD_RR) || (op == scp_pkg::OP_ADD_MR) ||
			(op == scp_pkg::OP_LD_M) || (op == scp_pkg::OP_MUL);
		c[scp_pkg::CTL_FLG] = (op == scp_pkg::OP_ADD_RR) ||
			(op == scp_pkg::OP_ADD_MR) || (op == scp_pkg::OP_MUL);
		c[scp_pkg::CTL_AMM] = (c[scp_pkg::CTL_MRD] || c[scp_pkg::CTL_MWR]) &&
			(am != scp_pkg::AM_DIRECT);
		decode = c;
	endfunction

	// reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'h0;
			rst_q_n    <= 1'h0;
		end else begin
			rst_meta_q <= 1'h1;
			rst_q_n    <= rst_meta_q;
		end
	end

	// five stage registers behind the fetch unit
	scp_stage_if nx_if [1:5] ();
	scp_stage_if st_if [1:5] ();

	for (genvar k = 1; k <= 5; k++) begin : g_stage
		assign nx_if[k].slot = nxs[k];
		assign sts[k] = st_if[k].slot;
		scp_stage u_stage (
			.clk_sys (clk_sys),
			.rst_n   (rst_q_n),
			.adv     (adv[k]),
			.nx      (nx_if[k].snk),
			.st      (st_if[k].src)
		);
	end

	// phase sequencer; a processor cycle closes at the end of phase two
	always_comb begin
		ph_d = (ph_q == scp_pkg::PH1) ? scp_pkg::PH2 : scp_pkg::PH1;
		tick = (ph_q == scp_pkg::PH2);
	end

	// stall network: each busy stage freezes itself and all before it
	always_comb begin
		ac_mc = sts[2].valid && sts[2].ctl[scp_pkg::CTL_AMM] &&
			(ac_cnt_q != scp_pkg::AC_LAST);
		// address unit must not read a base or index still being produced
		raw = sts[2].valid && sts[2].ctl[scp_pkg::CTL_AMM] &&
			((sts[3].valid && sts[3].ctl[scp_pkg::CTL_RWR] &&
			((rd_of(sts[3].ir) == rs_of(sts[2].ir)) ||
			(rd_of(sts[3].ir) == rx_of(sts[2].ir)))) ||
			(sts[4].valid && sts[4].ctl[scp_pkg::CTL_RWR] &&
			((rd_of(sts[4].ir) == rs_of(sts[2].ir)) ||
			(rd_of(sts[4].ir) == rx_of(sts[2].ir)))));
		of_rd = sts[3].valid && sts[3].ctl[scp_pkg::CTL_MRD];
		os_st = sts[5].valid && sts[5].ctl[scp_pkg::CTL_MWR];
		unique case (op_of(sts[4].ir))
			scp_pkg::OP_MUL:  ex_last = scp_pkg::MUL_LAST;
			scp_pkg::OP_BMOV: ex_last = sts[4].ir[scp_pkg::BCNT_HI:
				scp_pkg::BCNT_LO];
			default:          ex_last = '0;
		endcase
		busy[1] = 1'h0;
		busy[2] = ac_mc || raw;
		// one operand reference per cycle: a store in progress wins
		busy[3] = of_rd && (os_st || !dc_ready);
		busy[4] = sts[4].valid && (ex_cnt_q != ex_last);
		busy[5] = 1'h0;
		hold[5] = busy[5];
		for (int k = 4; k >= 1; k--) begin
			hold[k] = busy[k] || hold[k+1];
		end
		adv = {5{tick}} & ~hold;
	end

	// address arithmetic on the logical effective address
	always_comb begin
		logic [XL-1:0] disp;
		disp = {{(XL - scp_pkg::DISP_W){1'h0}},
			sts[2].ir[scp_pkg::DISP_HI:scp_pkg::DISP_LO]};
		unique case (scp_pkg::scp_am_t'(sts[2].ir[scp_pkg::AM_HI:
			scp_pkg::AM_LO]))
			scp_pkg::AM_DIRECT:   ea_calc = disp;
			scp_pkg::AM_BASE_IDX: ea_calc = rf_q[rs_of(sts[2].ir)] +
				rf_q[rx_of(sts[2].ir)];
			scp_pkg::AM_REL:      ea_calc = sts[2].pc + disp;
			scp_pkg::AM_REL_IDX:  ea_calc = sts[2].pc + disp +
				rf_q[rx_of(sts[2].ir)];
		endcase
	end

	// execute unit, 32-bit results for every operation
	always_comb begin
		ex_a = rf_q[rd_of(sts[4].ir)];
		ex_b = rf_q[rs_of(sts[4].ir)];
		add_b = (op_of(sts[4].ir) == scp_pkg::OP_ADD_MR) ? sts[4].opnd : ex_b;
		sum33 = {1'h0, ex_a} + {1'h0, add_b};
		unique case (op_of(sts[4].ir))
			scp_pkg::OP_ADD_RR,
			scp_pkg::OP_ADD_MR: ex_res = sum33[XL-1:0];
			scp_pkg::OP_LD_RR,
			scp_pkg::OP_ST_M:   ex_res = ex_b;
			scp_pkg::OP_LD_M,
			scp_pkg::OP_BMOV:   ex_res = sts[4].opnd;
			scp_pkg::OP_MUL:    ex_res = XL'(ex_a * ex_b);
			default:            ex_res = '0;
		endcase
		ex_fl = '0;
		ex_fl[scp_pkg::FL_Z] = (ex_res == '0);
		ex_fl[scp_pkg::FL_N] = ex_res[XL-1];
		ex_fl[scp_pkg::FL_C] = (op_of(sts[4].ir) != scp_pkg::OP_MUL) &&
			sum33[XL];
	end

	// what each stage takes from the one before it
	always_comb begin
		nxs[1] = '0;
		nxs[1].valid = fbuf_v_q;
		nxs[1].ir = fbuf_q;
		nxs[1].pc = fa_q;
		nxs[2] = sts[1];
		nxs[2].ctl = decode(sts[1].ir);
		nxs[3] = sts[2];
		nxs[3].valid = sts[2].valid && !busy[2];
		nxs[3].ea = tlb_paddr;
		nxs[4] = sts[3];
		nxs[4].valid = sts[3].valid && !busy[3];
		nxs[4].opnd = dc_rdata;
		nxs[5] = sts[4];
		nxs[5].valid = sts[4].valid && !busy[4];
		nxs[5].res = ex_res;
		nxs[5].fl = ex_fl;
		of_next = adv[3] ? nxs[3] : sts[3];
	end

	// fetch unit and stage occupancy counters
	always_comb begin
		pc_d = pc_q;
		fa_d = fa_q;
		fa_ok_d = fa_ok_q;
		if (tick && !hold[1]) begin
			fa_ok_d = ic_hit; // miss refetches the same address
			if (ic_hit) begin
				fa_d = pc_q;
				pc_d = pc_q + scp_pkg::PC_STEP;
			end
		end
		// word lands only after a fresh data access; a held slot keeps its word
		fbuf_d = ic_rd_q ? ic_rdata : fbuf_q;
		fbuf_v_d = (ph_q == scp_pkg::PH1) ? fa_ok_q : fbuf_v_q;
		ac_cnt_d = ac_cnt_q;
		if (tick && ac_mc) begin
			ac_cnt_d = ac_cnt_q + 4'h1;
		end else if (adv[3]) begin
			ac_cnt_d = '0;
		end
		ex_cnt_d = ex_cnt_q;
		if (tick) begin
			ex_cnt_d = busy[4] ? ex_cnt_q + 4'h1 : '0;
		end
	end

	// cache, translation and write-back strobes, one phase ahead
	always_comb begin
		ic_tag_d = (ph_d == scp_pkg::PH2);
		// data access only right after a tag hit that the fetch unit took
		ic_rd_d = tick && !hold[1] && ic_hit;
		ic_addr_d = (ph_d == scp_pkg::PH2) ? pc_q : fa_d;
		tlb_laddr_d = ea_calc;
		tlb_req_d = sts[2].valid &&
			(sts[2].ctl[scp_pkg::CTL_MRD] || sts[2].ctl[scp_pkg::CTL_MWR]);
		dc_addr_d = dc_addr_q;
		dc_tag_d = 1'h0;
		if (tick) begin
			dc_addr_d = (nxs[5].valid && nxs[5].ctl[scp_pkg::CTL_MWR]) ?
				nxs[5].ea : of_next.ea;
			dc_tag_d = (nxs[5].valid && nxs[5].ctl[scp_pkg::CTL_MWR]) ||
				(of_next.valid && of_next.ctl[scp_pkg::CTL_MRD]);
		end
		dc_rd_d = (ph_d == scp_pkg::PH2) && of_rd && !os_st;
		dc_wr_d = (ph_d == scp_pkg::PH2) && os_st;
		dc_wdata_d = sts[5].res;
		rf_we_d = tick && nxs[5].valid && sts[4].ctl[scp_pkg::CTL_RWR];
		rf_waddr_d = rd_of(sts[4].ir);
		rf_wdata_d = ex_res;
		flags_d = flags_q;
		if (tick && sts[5].valid && sts[5].ctl[scp_pkg::CTL_FLG]) begin
			flags_d = sts[5].fl;
		end
		retire_d = tick && sts[5].valid;
	end

	// register file written at the close of the execute cycle
	always_ff @(posedge clk_sys or negedge rst_q_n) begin
		if (!rst_q_n) begin
			for (int i = 0; i < scp_pkg::NREG; i++) begin
				rf_q[i] <= '0;
			end
		end else if (rf_we_d) begin
			rf_q[rf_waddr_d] <= rf_wdata_d;
		end
	end

	// control and output registers
	always_ff @(posedge clk_sys or negedge rst_q_n) begin
		if (!rst_q_n) begin
			ph_q        <= scp_pkg::PH1;
			pc_q        <= scp_pkg::PC_RST;
			fa_q        <= scp_pkg::PC_RST;
			fa_ok_q     <= 1'h0;
			fbuf_q      <= '0;
			fbuf_v_q    <= 1'h0;
			ac_cnt_q    <= '0;
			ex_cnt_q    <= '0;
			ic_addr_q   <= '0;
			ic_tag_q    <= 1'h0;
			ic_rd_q     <= 1'h0;
			tlb_laddr_q <= '0;
			tlb_req_q   <= 1'h0;
			dc_addr_q   <= '0;
			dc_tag_q    <= 1'h0;
			dc_rd_q     <= 1'h0;
			dc_wr_q     <= 1'h0;
			dc_wdata_q  <= '0;
			ext_wr_q    <= 1'h0;
			rf_we_q     <= 1'h0;
			rf_waddr_q  <= '0;
			rf_wdata_q  <= '0;
			flags_q     <= '0;
			retire_q    <= 1'h0;
		end else begin
			ph_q        <= ph_d;
			pc_q        <= pc_d;
			fa_q        <= fa_d;
			fa_ok_q     <= fa_ok_d;
			fbuf_q      <= fbuf_d;
			fbuf_v_q    <= fbuf_v_d;
			ac_cnt_q    <= ac_cnt_d;
			ex_cnt_q    <= ex_cnt_d;
			ic_addr_q   <= ic_addr_d;
			ic_tag_q    <= ic_tag_d;
			ic_rd_q     <= ic_rd_d;
			tlb_laddr_q <= tlb_laddr_d;
			tlb_req_q   <= tlb_req_d;
			dc_addr_q   <= dc_addr_d;
			dc_tag_q    <= dc_tag_d;
			dc_rd_q     <= dc_rd_d;
			dc_wr_q     <= dc_wr_d;
			dc_wdata_q  <= dc_wdata_d;
			ext_wr_q    <= dc_wr_d;
			rf_we_q     <= rf_we_d;
			rf_waddr_q  <= rf_waddr_d;
			rf_wdata_q  <= rf_wdata_d;
			flags_q     <= flags_d;
			retire_q    <= retire_d;
		end
	end

	assign phase_q = ph_q;
endmodule

// *** sim/scp_pipe_assertions.sv ***
`timescale 1ns/1ps
// phase use of the two cache references and write-back timing
module scp_pipe_assertions (
	input wire logic                     clk_sys,
	input wire logic                     rst_n,
	input wire logic                     ic_hit,
	input wire logic                     phase_q,
	input wire logic [scp_pkg::XLEN-1:0] ic_addr_q,
	input wire logic                     ic_tag_q,
	input wire logic                     ic_rd_q,
	input wire logic [scp_pkg::XLEN-1:0] dc_addr_q,
	input wire logic                     dc_tag_q,
	input wire logic                     dc_rd_q,
	input wire logic                     dc_wr_q,
	input wire logic                     ext_wr_q,
	input wire logic                     rf_we_q,
	input wire logic [scp_pkg::FL_W-1:0] flags_q,
	input wire logic                     retire_q
);
	logic [1:0] up_q;
	logic [1:0] up_d;

	// the design leaves reset two edges late, so checks wait for that
	always_comb begin
		up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			up_q <= 2'h0;
		end else begin
			up_q <= up_d;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n || up_q != 2'h3);

	a_phase_toggle: assert property (phase_q != $past(phase_q))
		else $error("phase did not alternate");
	a_itag_phase: assert property (ic_tag_q == phase_q)
		else $error("fetch tag compare outside phase two");
	a_fetch_data: assert property (ic_rd_q |-> !phase_q &&
		$past(ic_hit) && ic_addr_q == $past(ic_addr_q))
		else $error("fetch data access without a hit before it");
	a_otag_phase: assert property (dc_tag_q |-> !phase_q)
		else $error("operand tag compare outside phase one");
	a_odata_phase: assert property (dc_rd_q || dc_wr_q |->
		phase_q && $past(dc_tag_q) && $stable(dc_addr_q))
		else $error("operand data access not after its tag phase");
	a_two_refs: assert property (!(dc_rd_q && dc_wr_q) &&
		!(dc_tag_q && ic_tag_q))
		else $error("cache references collide in one phase");
	a_ext_store: assert property (ext_wr_q == dc_wr_q)
		else $error("external write apart from cache write");
	a_retire_ph1: assert property (retire_q |->
		!phase_q && !$past(retire_q))
		else $error("retire pulse out of place");
	a_rf_pulse: assert property (rf_we_q |=> !rf_we_q)
		else $error("register write longer than one clock");
	a_flag_time: assert property ($changed(flags_q) |->
		##[0:1] retire_q)
		else $error("flags changed away from operand store");
endmodule

bind scp_pipe scp_pipe_assertions u_scp_pipe_assertions (
	.clk_sys(clk_sys), .rst_n(rst_n), .ic_hit(ic_hit),
	.phase_q(phase_q), .ic_addr_q(ic_addr_q), .ic_tag_q(ic_tag_q),
	.ic_rd_q(ic_rd_q), .dc_addr_q(dc_addr_q), .dc_tag_q(dc_tag_q),
	.dc_rd_q(dc_rd_q), .dc_wr_q(dc_wr_q), .ext_wr_q(ext_wr_q),
	.rf_we_q(rf_we_q), .flags_q(flags_q), .retire_q(retire_q)
);

// *** sim/scp_cache_model.sv ***
`timescale 1ns/1ps
// cache and translation buffer; stalls are commanded by the bench
module scp_cache_model #(
	parameter logic [31:0] PA_OFS = 32'h0001_0000
) (
	input  wire logic [31:0] ic_addr_q,
	input  wire logic        ic_rd_q,
	input  wire logic [31:0] tlb_laddr_q,
	input  wire logic        tlb_req_q,
	input  wire logic [31:0] dc_addr_q,
	input  wire logic        dc_rd_q,
	input  wire logic        hit_en,
	input  wire logic        rdy_en,
	output logic [31:0]      ic_rdata,
	output logic             ic_hit,
	output logic [31:0]      tlb_paddr,
	output logic [31:0]      dc_rdata,
	output logic             dc_ready
);
	logic [31:0] mem [256];

	// outside its data phase a line shows the inverse, so late samples fail
	assign ic_rdata = ic_rd_q ? mem[ic_addr_q[9:2]]
		: ~mem[ic_addr_q[9:2]];
	assign ic_hit = hit_en;
	assign tlb_paddr = tlb_req_q ? tlb_laddr_q + PA_OFS
		: ~tlb_laddr_q;
	assign dc_rdata = dc_rd_q ? ~dc_addr_q : dc_addr_q;
	assign dc_ready = rdy_en;
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// one program run twice: clean for timing, then with random stalls
module testbench;
	localparam int N = 64;
	localparam logic [31:0] OFS = 32'h0001_0000;
	typedef struct packed {
		logic [3:0]  rd;
		logic [1:0]  kd;
		logic [31:0] v;
	} scp_exp_t;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        hit_en = 1'b1;
	logic        rdy_en = 1'b1;
	logic        run = 1'b0;
	logic        timed = 1'b0;
	logic [31:0] st = 32'h205b;
	logic [31:0] ic_rdata, tlb_paddr, dc_rdata, last_pa;
	logic [31:0] ic_addr_q, tlb_laddr_q, dc_addr_q, dc_wdata_q, rf_wdata_q;
	logic        ic_hit, dc_ready, phase_q, ic_tag_q, ic_rd_q, tlb_req_q;
	logic        dc_tag_q, dc_rd_q, dc_wr_q, ext_wr_q, rf_we_q, retire_q;
	logic [3:0]  rf_waddr_q;
	logic [2:0]  flags_q;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          nret, cyc, tlast, nst, nwr;
	int          cost [N];
	logic        wr [N];
	scp_exp_t    ex [N];
	scp_exp_t    exq [$];
	scp_exp_t    e;

	always #50 clk_sys = ~clk_sys;

	scp_pipe u_scp_pipe (
		.clk_sys(clk_sys), .rst_n(rst_n), .ic_rdata(ic_rdata),
		.ic_hit(ic_hit), .tlb_paddr(tlb_paddr), .dc_rdata(dc_rdata),
		.dc_ready(dc_ready), .phase_q(phase_q), .ic_addr_q(ic_addr_q),
		.ic_tag_q(ic_tag_q), .ic_rd_q(ic_rd_q), .tlb_laddr_q(tlb_laddr_q),
		.tlb_req_q(tlb_req_q), .dc_addr_q(dc_addr_q), .dc_tag_q(dc_tag_q),
		.dc_rd_q(dc_rd_q), .dc_wr_q(dc_wr_q), .dc_wdata_q(dc_wdata_q),
		.ext_wr_q(ext_wr_q), .rf_we_q(rf_we_q), .rf_waddr_q(rf_waddr_q),
		.rf_wdata_q(rf_wdata_q), .flags_q(flags_q), .retire_q(retire_q)
	);

	scp_cache_model #(.PA_OFS(OFS)) u_scp_cache_model (
		.ic_addr_q(ic_addr_q), .ic_rd_q(ic_rd_q), .tlb_laddr_q(tlb_laddr_q),
		.tlb_req_q(tlb_req_q), .dc_addr_q(dc_addr_q), .dc_rd_q(dc_rd_q),
		.hit_en(hit_en), .rdy_en(rdy_en), .ic_rdata(ic_rdata),
		.ic_hit(ic_hit), .tlb_paddr(tlb_paddr), .dc_rdata(dc_rdata),
		.dc_ready(dc_ready)
	);

	function automatic logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// simple ops write r8..r15; every eighth slot but the last holds a slow or memory op
	task automatic build();
		logic [31:0] r;
		logic [3:0]  op;
		logic [1:0]  am;
		int          k;
		for (int i = 0; i < 256; i++) begin
			u_scp_cache_model.mem[i] = 32'h0;
		end
		for (int i = 0; i < N; i++) begin
			r = rnd();
			k = (i % 8 == 4) ? i / 8 : 7;
			op = r[0] ? scp_pkg::OP_ADD_RR : scp_pkg::OP_LD_RR;
			case (k)
			0: op = scp_pkg::OP_MUL;
			1: op = scp_pkg::OP_BMOV;
			5: op = scp_pkg::OP_ST_M;
			2, 3, 4, 6: op = scp_pkg::OP_LD_M;
			default: ;
			endcase
			am = (k >= 2 && k <= 4) ? 2'(k - 1) : 2'h0;
			cost[i] = (k == 0) ? int'(scp_pkg::MUL_LAST) + 1
				: (k == 1) ? int'(r[3:0]) + 1
				: (am != 2'h0) ? int'(scp_pkg::AC_LAST) + 1 : 1;
			wr[i] = !(k == 1 || k == 5);
			ex[i] = '{{1'b1, r[3:1]}, (k == 6) ? 2'h1 : (am != 2'h0)
				? 2'h2 : 2'h0, ~({18'h0, r[13:0]} + OFS)};
			// memory ops use r0 as base and index, which nothing writes
			u_scp_cache_model.mem[i] = {op, am, ex[i].rd, (k >= 2 && k <= 6)
				? 4'h0 : {1'b1, r[6:4]}, 4'h0, r[13:0]};
		end
	endtask

	// reset, replay the program, stall at random when tm is low
	task automatic run_pass(input logic tm);
		logic [31:0] r;
		@(negedge clk_sys);
		rst_n = 1'b0;
		run = 1'b0;
		repeat (6) @(negedge clk_sys);
		exq = {};
		nwr = 0;
		// block move and store both write memory in operand store
		for (int i = 0; i < N; i++) begin
			if (wr[i]) exq.push_back(ex[i]);
			else nwr++;
		end
		nret = 0;
		cyc = 0;
		nst = 0;
		timed = tm;
		rst_n = 1'b1;
		run = 1'b1;
		for (int w = 0; w < 3000 && nret < N; w++) begin
			@(negedge clk_sys);
			r = rnd();
			hit_en = tm || r[1:0] != 2'h0;
			rdy_en = tm || r[3:2] != 2'h0;
		end
		hit_en = 1'b1;
		rdy_en = 1'b1;
		check(32'(nret >= N), 32'h1);
		check(32'(nst), 32'(nwr));
	endtask

	// scoreboard on registered outputs, read before this edge's updates
	always @(posedge clk_sys) begin
		if (run) begin
			if (dc_rd_q === 1'b1) last_pa = dc_addr_q;
			if (dc_wr_q === 1'b1) nst++;
			if (rf_we_q === 1'b1) begin
				e = exq.pop_front();
				check({28'h0, rf_waddr_q}, {28'h0, e.rd});
				if (e.kd == 2'h1) check(rf_wdata_q, e.v);
				if (e.kd == 2'h2) check(rf_wdata_q, ~last_pa);
			end
			if (retire_q === 1'b1) begin
				if (timed && nret > 0 && nret < N)
					check(32'(cyc - tlast), 32'(2 * cost[nret]));
				nret++;
				tlast = cyc;
			end
			cyc++;
		end
	end

	initial begin
		#1200000;
		num_errors++;
		give_verdict();
	end

	initial begin
		build();
		run_pass(1'b1);
		run_pass(1'b0);
		give_verdict();
	end
endmodule
